/* File: logic/fplk_front_panel.v */
// Purpose: status leds and push-button navigation of a trip unit panel
// Assumes: status inputs come from same-clock logic; keys and the
//          module sync line are pins and are synchronised here
// Notes:   registers over AHB-Lite, zero wait states, always OKAY
//
// How it works
// - the power led stays dark while the unit has no supply, save the battery flash.
// - powered from aux or service, power led steady or blinking per mode.
// - in alive mode with modules attached, blink phase follows modules.
// - warning led dark with no alarm, steady on prealarm or contact error.
// - alarm led steady after a trip, dark with no alarm.
// - alarm led blinks while timing to trip or a sensor is lost.
// - a hardware fault blinks warning and alarm leds together.
// - quick-info presses cycle alarm list, unit, breaker, last trip.
// - quick-info cycling works only from the measuring page.
// - unpowered with battery, quick-info briefly lights power led.
// - back key toggles measuring and main menu, goes up in submenus.
// - confirm opens main menu, enters submenus, accepts password, commits.
// - right/up scrolls, moves right or up, raises password digit by 1.
// - left/down scrolls, moves left or down, lowers password digit by 1.
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`include "fplk_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module fplk_front_panel #(
   parameter [23:0] BLINK_CYC = `FPLK_BLINK_CYC,
   parameter [25:0] FLASH_CYC = `FPLK_FLASH_CYC,
   parameter [17:0] DEB_CYC   = `FPLK_DEB_CYC
)(
   input  wire        ref_clk,
   input  wire        reset_n,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg  [31:0] hrdata,
   output reg         hresp,
   input  wire        quickInfoKey,
   input  wire        backKey,
   input  wire        confirmKey,
   input  wire        upKey,
   input  wire        downKey,
   input  wire        modSyncPin,
   input  wire        modPresent,
   input  wire        auxPower,
   input  wire        servicePower,
   input  wire        batteryOk,
   input  wire        preAlarm,
   input  wire        contactErr,
   input  wire        tripped,
   input  wire        tripTiming,
   input  wire        sensorLost,
   input  wire        hwFault,
   input  wire        alarmsPresent,
   input  wire        tripRecord,
   output reg         ledPower,
   output reg         ledWarn,
   output reg         ledAlarm,
   output reg         showTrip,
   output reg  [4:0]  screen,
   output reg  [1:0]  infoPage,
   output reg         irq
);
   localparam [4:0] ST_MEAS = 5'h01;
   localparam [4:0] ST_INFO = 5'h02;
   localparam [4:0] ST_MAIN = 5'h04;
   localparam [4:0] ST_SUB  = 5'h08;
   localparam [4:0] ST_PWD  = 5'h10;
   localparam       K_QI = 0;
   localparam       K_BK = 1;
   localparam       K_OK = 2;
   localparam       K_UP = 3;
   localparam       K_DN = 4;

   wire [4:0]  keyPin;
   wire [4:0]  press;
   reg  [2:0]  syncS_q;
   reg  [23:0] blinkCnt_q;
   reg         blink_q;
   reg  [25:0] flashCnt_q;
   reg         flashTrip_q;
   reg  [4:0]  nav_q;
   reg  [4:0]  nav_d;
   reg  [1:0]  page_q;
   reg  [1:0]  page_d;
   reg  [2:0]  meas_q;
   reg  [2:0]  meas_d;
   reg  [3:0]  pos_q;
   reg  [3:0]  pos_d;
   reg  [2:0]  lvl_q;
   reg  [2:0]  lvl_d;
   reg  [15:0] pwd_q;
   reg  [15:0] pwd_d;
   reg         pwdOk;
   reg         commit;
   reg  [3:0]  ctrl_q;
   reg  [7:0]  istat_q;
   reg  [7:0]  imask_q;
   reg         hwfDly_q;
   reg         wrPend_q;
   reg  [7:0]  wrAddr_q;
   reg  [31:0] rdData;
   wire        powered;
   wire        flashOn;
   wire        alive;
   wire [1:0]  digSel;
   wire [3:0]  dig;
   wire        addrPh;
   wire [7:0]  events;
   wire [7:0]  w1c;

   assign keyPin  = {downKey, upKey, confirmKey, backKey, quickInfoKey};
   assign powered = auxPower | servicePower;
   assign flashOn = flashCnt_q != 26'h0000000;
   assign alive   = ctrl_q[`FPLK_CTRL_ALIVE];
   assign digSel  = ctrl_q[`FPLK_CTRL_DIGSEL +: 2];
   assign dig     = pwd_q[{digSel, 2'b00} +: 4];

   // per key: two-flop sync, then a stable-time debounce
   genvar k;
   generate
      for (k = 0; k < 5; k = k + 1)
      begin : g_key
         reg        keyS1_q;
         reg        keyS2_q;
         reg        keyClean_q;
         reg        keyDly_q;
         reg [17:0] debCnt_q;
         assign press[k] = keyClean_q & ~keyDly_q;
         always @(posedge ref_clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               keyS1_q    <= 1'b0;
               keyS2_q    <= 1'b0;
               keyClean_q <= 1'b0;
               keyDly_q   <= 1'b0;
               debCnt_q   <= 18'h00000;
            end
            else
            begin
               keyS1_q  <= keyPin[k];
               keyS2_q  <= keyS1_q;
               keyDly_q <= keyClean_q;
               if (keyS2_q == keyClean_q)
                  debCnt_q <= 18'h00000;
               else if (debCnt_q >= DEB_CYC - 18'h00001)
               begin
                  keyClean_q <= keyS2_q;
                  debCnt_q   <= 18'h00000;
               end
               else
                  debCnt_q <= debCnt_q + 18'h00001;
            end
         end
      end
   endgenerate

   // one blink timebase for every led, realigned to the module line
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         syncS_q    <= 3'h0;
         blinkCnt_q <= 24'h000000;
         blink_q    <= 1'b0;
      end
      else
      begin
         syncS_q <= {syncS_q[1:0], modSyncPin};
         if (alive && modPresent && syncS_q[1] && !syncS_q[2])
         begin
            blinkCnt_q <= 24'h000000;
            blink_q    <= 1'b1;
         end
         else if (blinkCnt_q >= BLINK_CYC - 24'h000001)
         begin
            blinkCnt_q <= 24'h000000;
            blink_q    <= ~blink_q;
         end
         else
            blinkCnt_q <= blinkCnt_q + 24'h000001;
      end
   end

   // battery flash: the unit's own supply is absent; the menu still acts on keys
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         flashCnt_q  <= 26'h0000000;
         flashTrip_q <= 1'b0;
      end
      else if (!powered && batteryOk && press[K_QI])
      begin
         flashCnt_q  <= FLASH_CYC;
         flashTrip_q <= tripped;
      end
      else if (flashOn)
         flashCnt_q <= flashCnt_q - 26'h0000001;
      else
         flashTrip_q <= 1'b0;
   end

   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ledPower <= 1'b0;
         ledWarn  <= 1'b0;
         ledAlarm <= 1'b0;
         showTrip <= 1'b0;
      end
      else
      begin
         showTrip <= flashOn & flashTrip_q;
         if (!powered)
         begin
            ledPower <= flashOn;
            ledWarn  <= 1'b0;
            ledAlarm <= flashOn & flashTrip_q;
         end
         else
         begin
            ledPower <= alive ? blink_q : 1'b1;
            if (hwFault)
            begin
               ledWarn  <= blink_q;
               ledAlarm <= blink_q;
            end
            else
            begin
               ledWarn <= preAlarm | contactErr;
               if (tripped)
                  ledAlarm <= 1'b1;
               else
                  ledAlarm <= (tripTiming | sensorLost) & blink_q;
            end
         end
      end
   end

   // next quick-info page, skipping pages with nothing to show
   function [1:0] nextPage;
      input [1:0] p;
      input       al;
      input       tr;
      begin
         nextPage = p + 2'd1;
         if (nextPage == 2'd3 && !tr)
            nextPage = 2'd0;
         if (nextPage == 2'd0 && !al)
            nextPage = 2'd1;
      end
   endfunction

   always @*
   begin
      nav_d  = nav_q;
      page_d = page_q;
      meas_d = meas_q;
      pos_d  = pos_q;
      lvl_d  = lvl_q;
      pwd_d  = pwd_q;
      pwdOk  = 1'b0;
      commit = 1'b0;
      case (nav_q)
         ST_MEAS:
         begin
            if (press[K_QI])
            begin
               nav_d  = ST_INFO;
               page_d = alarmsPresent ? 2'd0 : 2'd1;
            end
            else if (press[K_BK] || press[K_OK])
            begin
               nav_d = ST_MAIN;
               pos_d = 4'h0;
            end
            else if (press[K_UP])
               meas_d = (meas_q == `FPLK_MEAS_PAGES) ? 3'h0
                                                     : meas_q + 3'h1;
            else if (press[K_DN])
               meas_d = (meas_q == 3'h0) ? `FPLK_MEAS_PAGES
                                         : meas_q - 3'h1;
         end
         ST_INFO:
         begin
            if (press[K_QI])
               page_d = nextPage(page_q, alarmsPresent, tripRecord);
            else if (press[K_BK])
               nav_d = ST_MEAS;
         end
         ST_MAIN:
         begin
            if (press[K_BK])
               nav_d = ST_MEAS;
            else if (press[K_OK])
            begin
               nav_d = ST_SUB;
               lvl_d = 3'h1;
            end
            else if (press[K_UP])
               pos_d = pos_q + 4'h1;
            else if (press[K_DN])
               pos_d = pos_q - 4'h1;
         end
         ST_SUB:
         begin
            if (press[K_BK])
            begin
               if (lvl_q == 3'h1)
                  nav_d = ST_MAIN;
               else
                  lvl_d = lvl_q - 3'h1;
            end
            else if (press[K_OK])
            begin
               if (ctrl_q[`FPLK_CTRL_PWDREQ])
                  nav_d = ST_PWD;
               else if (lvl_q == `FPLK_MAX_LEVEL)
                  commit = 1'b1;
               else
                  lvl_d = lvl_q + 3'h1;
            end
            else if (press[K_UP])
               pos_d = pos_q - 4'h1;
            else if (press[K_DN])
               pos_d = pos_q + 4'h1;
         end
         ST_PWD:
         begin
            if (press[K_OK])
            begin
               pwdOk = 1'b1;
               nav_d = ST_SUB;
            end
            else if (press[K_BK])
               nav_d = ST_SUB;
            else if (press[K_UP])
               pwd_d[{digSel, 2'b00} +: 4] =
                  (dig >= 4'h9) ? 4'h0 : dig + 4'h1;
            else if (press[K_DN])
               pwd_d[{digSel, 2'b00} +: 4] =
                  (dig == 4'h0 || dig > 4'h9) ? 4'h9
                                              : dig - 4'h1;
         end
         default:
            nav_d = ST_MEAS;
      endcase
   end

   assign addrPh = hsel & htrans[1] & hready;
   assign events = {commit, pwdOk, hwFault & ~hwfDly_q, press};
   assign w1c    = (wrPend_q && wrAddr_q == `FPLK_OFF_ISTAT)
                   ? hwdata[7:0] : 8'h00;

   always @*
   begin
      rdData = 32'h00000000;
      if (haddr[7:0] == `FPLK_OFF_CTRL)
         rdData[3:0] = ctrl_q;
      else if (haddr[7:0] == `FPLK_OFF_STAT)
      begin
         rdData[`FPLK_STAT_NAV +: 5]  = nav_q;
         rdData[`FPLK_STAT_INFO +: 2] = page_q;
         rdData[`FPLK_STAT_MEAS +: 3] = meas_q;
         rdData[`FPLK_STAT_POS +: 4]  = pos_q;
         rdData[`FPLK_STAT_LVL +: 3]  = lvl_q;
         rdData[`FPLK_STAT_FLASH]     = flashOn;
      end
      else if (haddr[7:0] == `FPLK_OFF_PWD)
         rdData[15:0] = pwd_q;
      else if (haddr[7:0] == `FPLK_OFF_ISTAT)
         rdData[7:0] = istat_q;
      else if (haddr[7:0] == `FPLK_OFF_IMASK)
         rdData[7:0] = imask_q;
   end

   // a software write to the password wins over a key in the same cycle
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         nav_q     <= ST_MEAS;
         page_q    <= 2'd0;
         meas_q    <= 3'h0;
         pos_q     <= 4'h0;
         lvl_q     <= 3'h0;
         pwd_q     <= `FPLK_PWD_RST;
         ctrl_q    <= `FPLK_CTRL_RST;
         istat_q   <= `FPLK_IRQ_RST;
         imask_q   <= `FPLK_IRQ_RST;
         hwfDly_q  <= 1'b0;
         wrPend_q  <= 1'b0;
         wrAddr_q  <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
         irq       <= 1'b0;
         screen    <= ST_MEAS;
         infoPage  <= 2'd0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         nav_q     <= nav_d;
         page_q    <= page_d;
         meas_q    <= meas_d;
         pos_q     <= pos_d;
         lvl_q     <= lvl_d;
         screen    <= nav_d;
         infoPage  <= page_d;
         hwfDly_q  <= hwFault;
         wrPend_q  <= addrPh & hwrite;
         if (addrPh)
            wrAddr_q <= haddr[7:0];
         if (addrPh && !hwrite)
            hrdata <= rdData;
         pwd_q <= pwd_d;
         if (wrPend_q)
         begin
            if (wrAddr_q == `FPLK_OFF_CTRL)
               ctrl_q <= hwdata[3:0];
            else if (wrAddr_q == `FPLK_OFF_PWD)
               pwd_q <= hwdata[15:0];
            else if (wrAddr_q == `FPLK_OFF_IMASK)
               imask_q <= hwdata[7:0];
         end
         // a new event beats a clear in the same cycle
         istat_q <= (istat_q & ~w1c) | events;
         irq     <= |(((istat_q & ~w1c) | events) & imask_q);
      end
   end
endmodule // fplk_front_panel
`default_nettype wire

/* File: logic/fplk_regs.vh */
// Purpose: constants of the front-panel led and key controller
// Assumes: 20 MHz ref_clk, AHB-Lite word registers
// Notes:   times in their own unit, cycle counts derived from them
`ifndef FPLK_REGS_VH
`define FPLK_REGS_VH
`define FPLK_CLK_KHZ      20000
`define FPLK_OFF_CTRL     8'h00
`define FPLK_OFF_STAT     8'h04
`define FPLK_OFF_PWD      8'h08
`define FPLK_OFF_ISTAT    8'h0C
`define FPLK_OFF_IMASK    8'h10
`define FPLK_CTRL_ALIVE   0
`define FPLK_CTRL_PWDREQ  1
`define FPLK_CTRL_DIGSEL  2
`define FPLK_CTRL_RST     4'h0
`define FPLK_PWD_RST      16'h0000
`define FPLK_IRQ_RST      8'h00
`define FPLK_STAT_NAV     0
`define FPLK_STAT_INFO    5
`define FPLK_STAT_MEAS    7
`define FPLK_STAT_POS     10
`define FPLK_STAT_LVL     14
`define FPLK_STAT_FLASH   17
`define FPLK_IRQ_KEY      0
`define FPLK_IRQ_HWF      5
`define FPLK_IRQ_PWDOK    6
`define FPLK_IRQ_COMMIT   7
`define FPLK_BLINK_MS     500
`define FPLK_FLASH_MS     2000
`define FPLK_DEB_MS       10
`define FPLK_BLINK_CYC    24'h989680
`define FPLK_FLASH_CYC    26'h2625A00
`define FPLK_DEB_CYC      18'h30D40
`define FPLK_MEAS_PAGES   3'h7
`define FPLK_MENU_ITEMS   4'hF
`define FPLK_MAX_LEVEL    3'h4
`endif

/* File: tb/fplk_front_panel_chk.sv */
// Purpose: port checks of the front panel controller
// Assumes: one clock, async active-low reset
// Notes:   blink half period measured by a counter
`timescale 1ns/1ps
`default_nettype none
module fplk_front_panel_chk #(
   parameter [23:0] BLINK_CYC = 24'h000008
)(
   input wire logic       ref_clk,
   input wire logic       reset_n,
   input wire logic       auxPower,
   input wire logic       servicePower,
   input wire logic       batteryOk,
   input wire logic       preAlarm,
   input wire logic       contactErr,
   input wire logic       tripped,
   input wire logic       tripTiming,
   input wire logic       sensorLost,
   input wire logic       hwFault,
   input wire logic       ledPower,
   input wire logic       ledWarn,
   input wire logic       ledAlarm,
   input wire logic       showTrip,
   input wire logic [4:0] screen,
   input wire logic [1:0] infoPage
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic [23:0] onCnt_q;
   wire         pwr = auxPower || servicePower;
   wire         noAl = !tripped && !tripTiming && !sensorLost && !hwFault;
   always @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
         onCnt_q <= 24'h000000;
      else
         onCnt_q <= ledWarn ? onCnt_q + 24'h000001 : 24'h000000;
   pwr_dark_a: assert property (
      !pwr && !batteryOk |=> !ledPower) else $error("power led lit");
   warn_dark_a: assert property (
      !preAlarm && !contactErr && !hwFault |=> !ledWarn)
      else $error("warning led lit");
   warn_on_a: assert property (
      (preAlarm || contactErr) && !hwFault |=> ledWarn)
      else $error("warning led dark");
   alarm_on_a: assert property (
      pwr && tripped && !tripTiming && !sensorLost && !hwFault |=> ledAlarm)
      else $error("alarm led dark after trip");
   alarm_dark_a: assert property (
      pwr && noAl |=> !ledAlarm) else $error("alarm led lit");
   hwf_pair_a: assert property (
      hwFault |=> ledWarn == ledAlarm) else $error("fault leds apart");
   blink_half_a: assert property (
      $fell(ledWarn) && hwFault && $past(hwFault, 20) |->
      onCnt_q == BLINK_CYC) else $error("blink half period wrong");
   info_meas_a: assert property (
      $changed(infoPage) |-> $past(screen) == 5'h01 ||
      $past(screen) == 5'h02) else $error("info page moved");
   meas_exit_a: assert property (
      $past(screen) == 5'h01 && screen != 5'h01 |->
      screen == 5'h02 || screen == 5'h04) else $error("bad exit");
   cover property (hwFault && ledWarn && ledAlarm);
   cover property (screen == 5'h10);
   cover property (showTrip && ledAlarm);
endmodule // fplk_front_panel_chk
`default_nettype wire

/* File: tb/fplk_front_panel_tb_top.sv */
// Purpose: self-checking bench of the front panel controller
// Assumes: blink 8, flash 20, debounce 3 cycles
// Notes:   keys come from the operator model
`include "fplk_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module fplk_front_panel_tb_top;
   logic        ref_clk, reset_n, hsel, hwrite, hreadyout, hresp;
   logic [1:0]  htrans, infoPage;
   logic [2:0]  hsize, keySel;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [4:0]  keys, screen;
   logic        go, busy, modSyncPin, modPresent, auxPower, servicePower;
   logic        batteryOk, preAlarm, contactErr, tripped, tripTiming;
   logic        sensorLost, hwFault, alarmsPresent, tripRecord;
   logic        ledPower, ledWarn, ledAlarm, showTrip, irq;
   int          nErrors, nTests, cycles;
   fplk_front_panel #(.BLINK_CYC(24'h8), .FLASH_CYC(26'h14),
      .DEB_CYC(18'h3)) fplk_front_panel_inst (.ref_clk(ref_clk),
      .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .quickInfoKey(keys[0]), .backKey(keys[1]), .confirmKey(keys[2]),
      .upKey(keys[3]), .downKey(keys[4]), .modSyncPin(modSyncPin),
      .modPresent(modPresent), .auxPower(auxPower),
      .servicePower(servicePower), .batteryOk(batteryOk),
      .preAlarm(preAlarm), .contactErr(contactErr), .tripped(tripped),
      .tripTiming(tripTiming), .sensorLost(sensorLost), .hwFault(hwFault),
      .alarmsPresent(alarmsPresent), .tripRecord(tripRecord),
      .ledPower(ledPower), .ledWarn(ledWarn), .ledAlarm(ledAlarm),
      .showTrip(showTrip), .screen(screen), .infoPage(infoPage), .irq(irq));
   fplk_operator fplk_operator_inst (.ref_clk(ref_clk), .keySel(keySel),
      .go(go), .keys(keys), .busy(busy));
   task endSim;
      $display("tests %0d errors %0d", nTests, nErrors);
      if (nErrors == 0 && nTests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      nTests++;
      if (s !== e)
      begin
         nErrors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // no pipelining: idle between transfers keeps the master simple
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task press(input logic [2:0] k);
      keySel <= k;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      while (busy) @(posedge ref_clk);
   endtask
   task st(input logic [5:0] s);
      {preAlarm, contactErr, tripped, tripTiming, sensorLost, hwFault} <= s;
   endtask
   task cnt(input int b, output int c);
      c = 0;
      repeat (3) @(posedge ref_clk);
      repeat (32)
      begin
         @(posedge ref_clk);
         c += int'({ledAlarm, ledWarn, ledPower} >> b) & 1;
      end
   endtask
   task t_regs;
      bus(1'b1, 8'h20, 32'hFFFFFFFF, rd);
      bus(1'b0, 8'h20, 32'h0, rd);
      chk(rd, 32'h0);
      bus(1'b0, `FPLK_OFF_PWD, 32'h0, rd);
      chk(rd, {16'h0000, `FPLK_PWD_RST});
      bus(1'b0, `FPLK_OFF_STAT, 32'h0, rd);
      chk(rd, 32'h1);
      chk(hresp, 1'b0);
   endtask
   task t_leds;
      int c;
      cnt(0, c);
      chk(c, 0);
      servicePower <= 1'b1;
      cnt(0, c);
      chk(c, 32);
      bus(1'b1, `FPLK_OFF_CTRL, 32'h1, rd);
      cnt(0, c);
      chk(c, 16);
      modPresent <= 1'b1;
      while (!ledPower) @(posedge ref_clk);
      while (ledPower) @(posedge ref_clk);
      modSyncPin <= 1'b1;
      repeat (2) @(posedge ref_clk);
      modSyncPin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(ledPower, 1'b1);
      modPresent <= 1'b0;
      st(6'h20);
      cnt(1, c);
      chk(c, 32);
      st(6'h10);
      cnt(1, c);
      chk(c, 32);
      st(6'h08);
      cnt(2, c);
      chk(c, 32);
      st(6'h04);
      cnt(2, c);
      chk(c, 16);
      st(6'h02);
      cnt(2, c);
      chk(c, 16);
      st(6'h01);
      cnt(1, c);
      chk(c, 16);
      st(6'h00);
      cnt(2, c);
      chk(c, 0);
   endtask
   task t_nav;
      alarmsPresent <= 1'b1;
      bus(1'b1, `FPLK_OFF_CTRL, 32'h2, rd);
      press(3'h4);
      bus(1'b0, `FPLK_OFF_STAT, 32'h0, rd);
      chk(rd[9:7], 3'h7);
      press(3'h3);
      bus(1'b0, `FPLK_OFF_STAT, 32'h0, rd);
      chk(rd[9:7], 3'h0);
      press(3'h0);
      chk(screen, 5'h02);
      chk(infoPage, 2'h0);
      press(3'h0);
      chk(infoPage, 2'h1);
      press(3'h0);
      chk(infoPage, 2'h2);
      press(3'h0);
      chk(infoPage, 2'h0);
      press(3'h1);
      press(3'h1);
      chk(screen, 5'h04);
      press(3'h0);
      chk(screen, 5'h04);
      press(3'h1);
      chk(screen, 5'h01);
      press(3'h2);
      chk(screen, 5'h04);
      press(3'h2);
      chk(screen, 5'h08);
      press(3'h2);
      chk(screen, 5'h10);
      press(3'h3);
      bus(1'b0, `FPLK_OFF_PWD, 32'h0, rd);
      chk(rd, 32'h1);
      press(3'h4);
      press(3'h4);
      bus(1'b0, `FPLK_OFF_PWD, 32'h0, rd);
      chk(rd, 32'h9);
      press(3'h3);
      bus(1'b0, `FPLK_OFF_PWD, 32'h0, rd);
      chk(rd, 32'h0);
      press(3'h2);
      bus(1'b0, `FPLK_OFF_ISTAT, 32'h0, rd);
      chk(rd & 32'h40, 32'h40);
      bus(1'b1, `FPLK_OFF_CTRL, 32'h0, rd);
      press(3'h3);
      repeat (4) press(3'h2);
      press(3'h1);
      chk(screen, 5'h08);
      bus(1'b0, `FPLK_OFF_STAT, 32'h0, rd);
      chk(rd[16:10], {3'h3, 4'hF});
      bus(1'b0, `FPLK_OFF_ISTAT, 32'h0, rd);
      chk(rd & 32'h80, 32'h80);
   endtask
   task t_irq;
      bus(1'b1, `FPLK_OFF_ISTAT, 32'hFF, rd);
      bus(1'b1, `FPLK_OFF_IMASK, 32'h2, rd);
      chk(irq, 1'b0);
      press(3'h1);
      chk(irq, 1'b1);
      bus(1'b1, `FPLK_OFF_ISTAT, 32'h2, rd);
      bus(1'b1, `FPLK_OFF_IMASK, 32'h0, rd);
      chk(irq, 1'b0);
      press(3'h1);
      bus(1'b0, `FPLK_OFF_ISTAT, 32'h0, rd);
      chk(rd, 32'h2);
      chk(irq, 1'b0);
   endtask
   task t_batt;
      servicePower <= 1'b0;
      batteryOk <= 1'b1;
      st(6'h08);
      repeat (3) @(posedge ref_clk);
      keySel <= 3'h0;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      while (!ledPower) @(posedge ref_clk);
      @(posedge ref_clk);
      chk(showTrip, 1'b1);
      chk(ledAlarm, 1'b1);
      repeat (30) @(posedge ref_clk);
      chk(ledPower, 1'b0);
      while (busy) @(posedge ref_clk);
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // ceiling well above the roughly 1200 cycles the tasks take
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         nErrors++;
         endSim;
      end
   end
   initial
   begin
      {reset_n, hsel, hwrite, htrans, haddr, hwdata, keySel, go} = '0;
      {modSyncPin, modPresent, auxPower, servicePower, batteryOk} = '0;
      {preAlarm, contactErr, tripped, tripTiming, sensorLost} = '0;
      {hwFault, alarmsPresent, tripRecord} = '0;
      {nErrors, nTests, cycles} = '0;
      hsize = 3'h2;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      t_regs;
      t_leds;
      t_nav;
      t_irq;
      t_batt;
      endSim;
   end
endmodule // fplk_front_panel_tb_top
bind fplk_front_panel fplk_front_panel_chk #(.BLINK_CYC(BLINK_CYC))
   fplk_front_panel_chk_inst (.ref_clk(ref_clk), .reset_n(reset_n),
   .auxPower(auxPower), .servicePower(servicePower), .batteryOk(batteryOk),
   .preAlarm(preAlarm), .contactErr(contactErr), .tripped(tripped),
   .tripTiming(tripTiming), .sensorLost(sensorLost), .hwFault(hwFault),
   .ledPower(ledPower), .ledWarn(ledWarn), .ledAlarm(ledAlarm),
   .showTrip(showTrip), .screen(screen), .infoPage(infoPage));
`default_nettype wire

/* File: tb/fplk_operator.sv */
// Purpose: push-button operator at the far side of the panel
// Assumes: go is pulsed with a key index while busy is low
// Notes:   each press opens with a one-cycle bounce
`timescale 1ns/1ps
`default_nettype none
module fplk_operator (
   input  wire logic       ref_clk,
   input  wire logic [2:0] keySel,
   input  wire logic       go,
   output wire logic [4:0] keys,
   output var  logic       busy
);
   logic [4:0] step_q = 5'h00;
   initial busy = 1'b0;
   // short bounce, long hold, long release: one count
   assign keys = (busy && step_q != 5'h01 && step_q < 5'h0E) ?
                 5'h01 << keySel : 5'h00;
   always @(posedge ref_clk)
   begin
      if (go && !busy)
         busy <= 1'b1;
      else if (step_q == 5'h1B)
         busy <= 1'b0;
      step_q <= busy ? step_q + 5'h01 : 5'h00;
   end
endmodule // fplk_operator
`default_nettype wire
